// ==== rtl/wave_halt_pkg.sv ====
// constants and carrier types for the waveform auto-shutdown block
// assumes a 32-bit classic wishbone slave with word-aligned registers
package wave_halt_pkg;
   localparam logic [7:0] OFF_HALT_CTRL  = 8'h00;
   localparam logic [7:0] OFF_SRC_EN     = 8'h04;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h0C;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
   localparam int BIT_HALT    = 0;
   localparam int BIT_RESTART = 1;
   localparam int POS_LVL_BD  = 2;
   localparam int POS_LVL_AC  = 4;
   localparam int NUM_SRC     = 7;
   localparam int NUM_IRQ     = 1;
   localparam logic [NUM_SRC-1:0] SRC_EN_RESET = 7'h00;
   localparam logic [1:0]         LVL_RESET    = 2'h0;

   // fault inputs, all active low
   typedef struct packed {
      logic       fault_pin_n;
      logic [2:0] timer_period_pulse_n;
      logic [1:0] comparator_n;
      logic       logic_cell_two_n;
   } fault_in_s;

   // waveform outputs a..d
   typedef struct packed {
      logic a;
      logic b;
      logic c;
      logic d;
   } wave_out_s;

   typedef enum logic [1:0] {RUNNING, HALTED, WAIT_EDGE} run_e;
endpackage : wave_halt_pkg

// ==== rtl/waveform_auto_shutdown.sv ====
// auto-shutdown and restart stage in front of the waveform output pins
// assumes fault inputs and data input are synchronous to clk_i
`timescale 1ns/1ns
`default_nettype none

module waveform_auto_shutdown
   import wave_halt_pkg::*;
(
   input  wire  logic                     clk_i,   // 50 MHz clock
   input  wire  logic                     rst_i,   // sync reset, active high
   input  wire  logic                     cyc_i,   // wishbone cycle
   input  wire  logic                     stb_i,   // wishbone strobe
   input  wire  logic                     we_i,    // wishbone write
   input  wire  logic [7:0]               adr_i,   // byte address
   input  wire  logic [3:0]               sel_i,   // byte selects
   input  wire  logic [31:0]              dat_i,   // write data
   output var   logic [31:0]              dat_o,   // read data
   output var   logic                     ack_o,   // wishbone ack
   input  wire  wave_halt_pkg::fault_in_s fault_i, // fault sources
   input  wire  logic                     data_i,  // waveform data input
   input  wire  wave_halt_pkg::wave_out_s wave_i,  // generator outputs
   output var   wave_halt_pkg::wave_out_s wave_o,  // pin outputs
   output var   logic                     halted_o,// shutdown in force
   output var   logic                     irq_o    // level interrupt
);
   import wave_halt_pkg::*;

   typedef struct packed {
      logic               halt;
      logic               restart_en;
      logic [1:0]         lvl_bd;
      logic [1:0]         lvl_ac;
      logic [NUM_SRC-1:0] src_en;
      logic [NUM_IRQ-1:0] irq_status;
      logic [NUM_IRQ-1:0] irq_enable;
      run_e               run;
      logic               data_q;
      logic               ack;
      logic [31:0]        rdata;
   } state_s;

   state_s st;
   state_s next_st;

   logic [NUM_SRC-1:0] fault_raw;
   logic               fault_active;
   logic               wr;
   logic               rd;
   logic               halt_rise;
   logic               data_rise;
   logic               shut_now;

   // level for an override field: 00 low, 01 high, 1x idle low
   function automatic logic lvl_out(input logic [1:0] lvl);
      lvl_out = (lvl == 2'h1);
   endfunction : lvl_out

   // control register decode, shared by the auto-clear guard and the checks
   function automatic logic ctrl_hit(input logic [7:0] adr);
      ctrl_hit = (adr == OFF_HALT_CTRL);
   endfunction : ctrl_hit

   assign fault_raw    = ~{fault_i.fault_pin_n, fault_i.timer_period_pulse_n,
                           fault_i.comparator_n, fault_i.logic_cell_two_n};
   assign fault_active = |(fault_raw & st.src_en);
   // writes land on the edge where the master samples ack high
   assign wr           = cyc_i & stb_i & we_i & st.ack;
   assign rd           = cyc_i & stb_i & ~we_i & ~st.ack;
   assign data_rise    = data_i & ~st.data_q;
   assign shut_now     = fault_active | st.run != RUNNING;

   always_comb begin
      next_st        = st;
      next_st.ack    = cyc_i & stb_i & ~st.ack;
      next_st.data_q = data_i;
      halt_rise      = 1'b0;
      if (wr & sel_i[0]) begin
         case (adr_i)
            OFF_HALT_CTRL: begin
               next_st.restart_en = dat_i[BIT_RESTART];
               next_st.lvl_bd     = dat_i[POS_LVL_BD +: 2];
               next_st.lvl_ac     = dat_i[POS_LVL_AC +: 2];
               if (dat_i[BIT_HALT] | ~fault_active) begin
                  next_st.halt = dat_i[BIT_HALT];
               end
            end
            OFF_SRC_EN:     next_st.src_en = dat_i[NUM_SRC-1:0];
            OFF_IRQ_CLEAR:  next_st.irq_status = st.irq_status & ~dat_i[NUM_IRQ-1:0];
            OFF_IRQ_ENABLE: next_st.irq_enable = dat_i[NUM_IRQ-1:0];
            default: ;
         endcase
      end
      if (fault_active) begin
         next_st.halt = 1'b1;
      end
      // with restart_en set, hardware clears flag once faults gone
      else if (st.restart_en & st.halt & ~(wr & sel_i[0] & ctrl_hit(adr_i))) begin
         next_st.halt = 1'b0;
      end
      halt_rise = next_st.halt & ~st.halt;
      if (halt_rise) begin
         next_st.irq_status[0] = 1'b1;
      end
      case (st.run)
         RUNNING: begin
            if (st.halt | fault_active) begin
               next_st.run = HALTED;
            end
         end
         HALTED: begin
            if (~st.halt & ~fault_active) begin
               next_st.run = WAIT_EDGE;
            end
         end
         WAIT_EDGE: begin
            if (st.halt | fault_active) begin
               next_st.run = HALTED;
            end else if (data_rise) begin
               next_st.run = RUNNING;
            end
         end
         default: next_st.run = HALTED;
      endcase
      next_st.rdata = 32'h0000_0000;
      if (rd) begin
         case (adr_i)
            OFF_HALT_CTRL:  next_st.rdata = {26'h000_0000, st.lvl_ac, st.lvl_bd, st.restart_en, st.halt};
            OFF_SRC_EN:     next_st.rdata = {25'h000_0000, st.src_en};
            OFF_IRQ_STATUS: next_st.rdata = {31'h0000_0000, st.irq_status};
            OFF_IRQ_ENABLE: next_st.rdata = {31'h0000_0000, st.irq_enable};
            default:        next_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st            <= '0;
         st.run        <= RUNNING;
         st.src_en     <= SRC_EN_RESET;
         st.lvl_bd     <= LVL_RESET;
         st.lvl_ac     <= LVL_RESET;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      wave_o = wave_i;
      if (shut_now) begin
         wave_o.a = lvl_out(st.lvl_ac);
         wave_o.c = lvl_out(st.lvl_ac);
         wave_o.b = lvl_out(st.lvl_bd);
         wave_o.d = lvl_out(st.lvl_bd);
      end
   end

   assign dat_o    = st.rdata;
   assign ack_o    = st.ack;
   assign halted_o = shut_now;
   assign irq_o    = |(st.irq_status & st.irq_enable);

   property p_fault_sets_halt;
      @(posedge clk_i) disable iff (rst_i) fault_active |=> st.halt;
   endproperty
   a_fault_sets_halt: assert property (p_fault_sets_halt) else $error("fault did not set halt");

   property p_fault_overrides;
      @(posedge clk_i) disable iff (rst_i) fault_active |-> halted_o;
   endproperty
   a_fault_overrides: assert property (p_fault_overrides) else $error("fault did not override");

   property p_halt_irq;
      @(posedge clk_i) disable iff (rst_i) $rose(st.halt) |-> st.irq_status[0];
   endproperty
   a_halt_irq: assert property (p_halt_irq) else $error("halt without irq flag");

   property p_manual_hold;
      @(posedge clk_i) disable iff (rst_i) (st.halt & ~st.restart_en & ~wr) |=> st.halt;
   endproperty
   a_manual_hold: assert property (p_manual_hold) else $error("halt dropped without write");

   property p_auto_clear;
      @(posedge clk_i) disable iff (rst_i) (st.halt & st.restart_en & ~fault_active & ~wr) |=> ~st.halt;
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("auto restart did not clear");

   sequence s_waiting;
      st.run == WAIT_EDGE && !fault_active && !st.halt;
   endsequence
   property p_resume_edge;
      @(posedge clk_i) disable iff (rst_i) s_waiting ##0 data_rise |=> st.run == RUNNING;
   endproperty
   a_resume_edge: assert property (p_resume_edge) else $error("no resume on data edge");

   property p_no_early_resume;
      @(posedge clk_i) disable iff (rst_i) (st.run == WAIT_EDGE && !data_rise) |=> st.run != RUNNING;
   endproperty
   a_no_early_resume: assert property (p_no_early_resume) else $error("resumed without edge");

   property p_override_levels;
      @(posedge clk_i) disable iff (rst_i)
         halted_o |-> (wave_o.a == (st.lvl_ac == 2'h1)) && (wave_o.d == (st.lvl_bd == 2'h1));
   endproperty
   a_override_levels: assert property (p_override_levels) else $error("wrong override level");

   property p_clear_refused;
      @(posedge clk_i) disable iff (rst_i) (fault_active && st.halt) |=> st.halt;
   endproperty
   a_clear_refused: assert property (p_clear_refused) else $error("halt cleared under fault");

   property p_ack_one_cycle;
      @(posedge clk_i) disable iff (rst_i)
         ack_o |=> !ack_o;
   endproperty
   a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack held too long");

   property p_ack_follows_req;
      @(posedge clk_i) disable iff (rst_i)
         (cyc_i && stb_i && !ack_o) |=> ack_o;
   endproperty
   a_ack_follows_req: assert property (p_ack_follows_req) else $error("request not acknowledged");

   property p_ack_needs_req;
      @(posedge clk_i) disable iff (rst_i)
         ack_o |-> $past(cyc_i) && $past(stb_i);
   endproperty
   a_ack_needs_req: assert property (p_ack_needs_req) else $error("ack without request");

   property p_rdata_idle;
      @(posedge clk_i) disable iff (rst_i)
         !ack_o |-> dat_o == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ack");

   property p_pass_through;
      @(posedge clk_i) disable iff (rst_i)
         (st.run == RUNNING && !fault_active) |-> wave_o == wave_i;
   endproperty
   a_pass_through: assert property (p_pass_through) else $error("outputs blocked while running");

   property p_halt_forces_shutdown;
      @(posedge clk_i) disable iff (rst_i)
         st.halt |=> halted_o;
   endproperty
   a_halt_forces_shutdown: assert property (p_halt_forces_shutdown) else $error("halt did not shut down");

   sequence s_halt_held;
      st.halt ##1 st.halt;
   endsequence
   property p_manual_stays;
      @(posedge clk_i) disable iff (rst_i)
         s_halt_held |-> st.run != RUNNING;
   endproperty
   a_manual_stays: assert property (p_manual_stays) else $error("ran while halt held");

   property p_irq_raised;
      @(posedge clk_i) disable iff (rst_i)
         (st.irq_status[0] && st.irq_enable[0]) |-> irq_o;
   endproperty
   a_irq_raised: assert property (p_irq_raised) else $error("enabled status without irq");

   property p_irq_quiet;
      @(posedge clk_i) disable iff (rst_i)
         !st.irq_status[0] |-> !irq_o;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("irq without status");

   sequence s_sw_halt;
      wr && sel_i[0] && ctrl_hit(adr_i) && dat_i[BIT_HALT] && !st.halt;
   endsequence
   property p_sw_halt_irq;
      @(posedge clk_i) disable iff (rst_i)
         s_sw_halt |=> st.halt && st.irq_status[0];
   endproperty
   a_sw_halt_irq: assert property (p_sw_halt_irq) else $error("software halt without irq");

   property p_sw_clear_ok;
      @(posedge clk_i) disable iff (rst_i)
         (wr && sel_i[0] && ctrl_hit(adr_i) && !dat_i[BIT_HALT] && !fault_active) |=> !st.halt;
   endproperty
   a_sw_clear_ok: assert property (p_sw_clear_ok) else $error("software clear lost");

   property p_restart_needs_clear;
      @(posedge clk_i) disable iff (rst_i)
         (st.run == HALTED && (st.halt || fault_active)) |=> st.run == HALTED;
   endproperty
   a_restart_needs_clear: assert property (p_restart_needs_clear) else $error("left shutdown early");

   property p_wait_after_clear;
      @(posedge clk_i) disable iff (rst_i)
         (st.run == HALTED && !st.halt && !fault_active) |=> st.run == WAIT_EDGE;
   endproperty
   a_wait_after_clear: assert property (p_wait_after_clear) else $error("no wait for data edge");

   property p_reset_values;
      @(posedge clk_i) disable iff (rst_i)
         $fell(rst_i) |-> !st.halt && !st.restart_en && st.src_en == SRC_EN_RESET && st.lvl_bd == LVL_RESET;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset state wrong");

   property p_pair_match;
      @(posedge clk_i) disable iff (rst_i)
         halted_o |-> (wave_o.c == wave_o.a) && (wave_o.b == wave_o.d);
   endproperty
   a_pair_match: assert property (p_pair_match) else $error("pair outputs differ");

   property p_level_idle;
      @(posedge clk_i) disable iff (rst_i)
         (halted_o && st.lvl_ac != 2'h1) |-> !wave_o.a;
   endproperty
   a_level_idle: assert property (p_level_idle) else $error("override not low");
endmodule : waveform_auto_shutdown

`default_nettype wire

// ==== testbench/wave_partner.sv ====
// stand-in for the fault sources and the waveform generator stage
// assumes the bench drives its controls on the rising clock edge
`timescale 1ns/1ns
`default_nettype none
module wave_partner
   import wave_halt_pkg::*;
(
   input  wire logic                     clk_i,   // clock
   input  wire logic                     rst_i,   // sync reset
   input  wire logic [6:0]               low_i,   // sources pulled low
   input  wire logic                     run_i,   // data input may toggle
   output var  wave_halt_pkg::fault_in_s fault_o, // fault levels
   output var  logic                     data_o,  // data input
   output var  wave_halt_pkg::wave_out_s wave_o   // generator outputs
);
   logic [3:0] cnt;
   assign fault_o = fault_in_s'(~low_i);
   // pattern moves every cycle so a stuck override never matches by luck
   assign wave_o  = wave_out_s'(cnt);
   assign data_o  = run_i & cnt[2];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule : wave_partner
`default_nettype wire

// ==== testbench/waveform_auto_shutdown_tb_top.sv ====
// self-checking bench for the auto-shutdown block
// assumes one 50 MHz clock and the partner model on the fault side
`timescale 1ns/1ns
`default_nettype none
module waveform_auto_shutdown_tb_top;
   import wave_halt_pkg::*;
   typedef struct packed {logic [6:0] src; logic [1:0] bd; logic [1:0] ac; logic [3:0] exp;} row_s;
   logic        clk_i, rst_i, cyc, stb, we, ack_o, halted_o, irq_o, data_i, run;
   logic [7:0]  adr;
   logic [31:0] dat, dat_o, rd;
   logic [6:0]  low;
   fault_in_s   fault_i;
   wave_out_s   wave_i, wave_o;
   int          error_cnt, checked;
   row_s rows [7] = '{'{7'h40, 2'h1, 2'h0, 4'h5}, '{7'h20, 2'h0, 2'h1, 4'hA}, '{7'h10, 2'h1, 2'h1, 4'hF},
      '{7'h08, 2'h2, 2'h3, 4'h0}, '{7'h04, 2'h3, 2'h1, 4'hA}, '{7'h02, 2'h1, 2'h2, 4'h5}, '{7'h01, 2'h0, 2'h0, 4'h0}};
   waveform_auto_shutdown dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .fault_i(fault_i), .data_i(data_i), .wave_i(wave_i),
      .wave_o(wave_o), .halted_o(halted_o), .irq_o(irq_o));
   wave_partner model_u (.clk_i(clk_i), .rst_i(rst_i), .low_i(low), .run_i(run), .fault_o(fault_i),
      .data_o(data_i), .wave_o(wave_i));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out;
      $display("mismatches %0d of %0d compares", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic ran_out;
      error_cnt++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      close_out();
   endtask : ran_out
   // holds the request until ack is sampled, then releases for one idle cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) break;
      end
      if (n == 20) ran_out();
      rd = dat_o;
      {cyc, stb, we} <= 3'b000;
      #1;
   endtask : wb
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask : rd_chk
   task automatic wait_run;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk_i);
         #1;
         if (halted_o === 1'b0) return;
      end
      ran_out();
   endtask : wait_run
   initial begin
      {rst_i, cyc, stb, we, adr, dat, low, run, error_cnt, checked} = {1'b1, 50'h0, 1'b1, 64'h0};
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(OFF_HALT_CTRL, 32'h0);
      rd_chk(OFF_SRC_EN, 32'h0);
      rd_chk(8'h20, 32'h0);
      check(32'(halted_o), 32'h0);
      foreach (rows[i]) begin
         wb(1'b1, OFF_HALT_CTRL, 32'({rows[i].ac, rows[i].bd, 2'h0}));
         wb(1'b1, OFF_SRC_EN, 32'(rows[i].src));
         @(posedge clk_i) low <= ~rows[i].src;
         #1 check(32'(halted_o), 32'h0);
         @(posedge clk_i) low <= rows[i].src;
         #1 check(32'(wave_o), 32'(rows[i].exp));
         wb(1'b1, OFF_HALT_CTRL, 32'h0);
         rd_chk(OFF_HALT_CTRL, 32'h1);
         rd_chk(OFF_IRQ_STATUS, 32'h1);
         @(posedge clk_i) low <= 7'h00;
         wb(1'b1, OFF_HALT_CTRL, 32'h0);
         rd_chk(OFF_HALT_CTRL, 32'h0);
         wait_run();
         check(32'(wave_o), 32'(wave_i));
         wb(1'b1, OFF_IRQ_CLEAR, 32'h1);
         rd_chk(OFF_IRQ_STATUS, 32'h0);
      end
      wb(1'b1, OFF_IRQ_ENABLE, 32'h1);
      wb(1'b1, OFF_HALT_CTRL, 32'h1);
      check(32'(irq_o), 32'h1);
      repeat (12) @(posedge clk_i);
      #1 check(32'({halted_o, wave_o}), 32'h10);
      wb(1'b1, OFF_IRQ_ENABLE, 32'h0);
      check(32'(irq_o), 32'h0);
      wb(1'b1, OFF_IRQ_ENABLE, 32'h1);
      check(32'(irq_o), 32'h1);
      wb(1'b1, OFF_IRQ_CLEAR, 32'h1);
      check(32'(irq_o), 32'h0);
      wb(1'b1, OFF_HALT_CTRL, 32'h0);
      wait_run();
      @(posedge clk_i) run <= 1'b0;
      wb(1'b1, OFF_HALT_CTRL, 32'h2);
      wb(1'b1, OFF_SRC_EN, 32'h1);
      @(posedge clk_i) low <= 7'h01;
      repeat (5) @(posedge clk_i);
      rd_chk(OFF_HALT_CTRL, 32'h3);
      @(posedge clk_i) low <= 7'h00;
      repeat (3) @(posedge clk_i);
      rd_chk(OFF_HALT_CTRL, 32'h2);
      check(32'(halted_o), 32'h1);
      @(posedge clk_i) run <= 1'b1;
      wait_run();
      check(32'(wave_o), 32'(wave_i));
      close_out();
   end
endmodule : waveform_auto_shutdown_tb_top
`default_nettype wire
